// ===== hw/jtmap_tap.sv
// test access port controller with memory access toward the system clock side
`timescale 1ns/100ps
module jtmap_tap import jtmap_pkg::*; #(
	parameter logic [3:0] ID_VERSION = 4'h2, // arbitrary value
	parameter logic [15:0] ID_PART = 16'h5A3C, // arbitrary value
	parameter logic [10:0] ID_MAKER = 11'h2B5 // arbitrary value
) (
	// system clock, reset, enable
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic clk_en_in,
	// test port pins
	input wire logic tck_in,
	input wire logic tms_in,
	input wire logic tdi_in,
	output logic tdo_out,
	output logic tdo_oe_out,
	// memory side, system clock domain
	output logic [MEM_W-1:0] mem_addr_out,
	output logic [MEM_W-1:0] mem_wdata_out,
	output logic mem_wr_out,
	output logic mem_rd_out,
	input wire logic [MEM_W-1:0] mem_rdata_in,
	input wire logic mem_rvalid_in,
	input wire logic twi_busy_in,
	output logic jtag_busy_out,
	output logic mem_refused_out,
	// device actions
	output logic reboot_out,
	output logic save_out,
	output logic ext_page_out,
	output logic eep_page_out,
	// user identification fields, quasi-static
	input wire logic [15:0] user_code_in
);

	////////////////////////////////////////////////////////////////
	// test clock domain

	logic rst_s1_q;
	logic tap_rst_q;
	jtmap_state_t state_q;
	jtmap_state_t state_d;
	logic [IR_W-1:0] ir_sh_q;
	logic [IR_W-1:0] ir_q;
	logic [ID_W-1:0] dr_sh_q;
	logic bypass_q;
	logic [MEM_W-1:0] addr_q;
	logic [MEM_W-1:0] wdata_q;
	jtmap_cmd_t cmd_q;
	logic req_tgl_q;
	logic tdo_q;
	logic tdo_oe_q;
	logic [15:0] user_s1_q;
	logic [15:0] user_s2_q;
	logic rd_tgl_s1_q;
	logic rd_tgl_s2_q;
	logic rd_tgl_s3_q;
	logic [MEM_W-1:0] rd_hold_q;
	logic [ID_W-1:0] id_word;
	logic is_mem_ins;
	// read return, written on the system clock side
	logic [MEM_W-1:0] rdata_q;
	logic rd_tgl_q;

	// fixed bit zero set in identification word
	assign id_word = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
	assign is_mem_ins = (ir_q == INS_LOAD_ADDR) || (ir_q == INS_READ_DATA) ||
		(ir_q == INS_WRITE_DATA);

	// reset brought into test clock domain
	always_ff @(posedge tck_in) begin
		rst_s1_q <= sys_rst_in;
		tap_rst_q <= rst_s1_q;
	end

	// next state from sampled mode-select
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			JT_TLR: state_d = tms_in ? JT_TLR : JT_RTI;
			JT_RTI: state_d = tms_in ? JT_SELDR : JT_RTI;
			JT_SELDR: state_d = tms_in ? JT_SELIR : JT_CAPDR;
			JT_CAPDR: state_d = tms_in ? JT_EX1DR : JT_SHDR;
			JT_SHDR: state_d = tms_in ? JT_EX1DR : JT_SHDR;
			JT_EX1DR: state_d = tms_in ? JT_UPDDR : JT_PAUSEDR;
			JT_PAUSEDR: state_d = tms_in ? JT_EX2DR : JT_PAUSEDR;
			JT_EX2DR: state_d = tms_in ? JT_UPDDR : JT_SHDR;
			JT_UPDDR: state_d = tms_in ? JT_SELDR : JT_RTI;
			JT_SELIR: state_d = tms_in ? JT_TLR : JT_CAPIR;
			JT_CAPIR: state_d = tms_in ? JT_EX1IR : JT_SHIR;
			JT_SHIR: state_d = tms_in ? JT_EX1IR : JT_SHIR;
			JT_EX1IR: state_d = tms_in ? JT_UPDIR : JT_PAUSEIR;
			JT_PAUSEIR: state_d = tms_in ? JT_EX2IR : JT_PAUSEIR;
			JT_EX2IR: state_d = tms_in ? JT_UPDIR : JT_SHIR;
			JT_UPDIR: state_d = tms_in ? JT_SELDR : JT_RTI;
		endcase
	end

	// state register on rising test clock
	always_ff @(posedge tck_in) begin
		if (tap_rst_q) begin
			state_q <= JT_TLR;
		end else begin
			state_q <= state_d;
		end
	end

	// instruction shifter: capture constant, shift toward output
	always_ff @(posedge tck_in) begin
		if (tap_rst_q) begin
			ir_sh_q <= IR_CAPTURE;
		end else if (state_q == JT_CAPIR) begin
			ir_sh_q <= IR_CAPTURE;
		end else if (state_q == JT_SHIR) begin
			ir_sh_q <= {tdi_in, ir_sh_q[IR_W-1:1]};
		end
	end

	// user code fields synchronised into test clock domain
	always_ff @(posedge tck_in) begin
		user_s1_q <= user_code_in;
		user_s2_q <= user_s1_q;
	end

	// read data returned from system side, taken on toggle
	always_ff @(posedge tck_in) begin
		if (tap_rst_q) begin
			rd_tgl_s1_q <= 1'b0;
			rd_tgl_s2_q <= 1'b0;
			rd_tgl_s3_q <= 1'b0;
			rd_hold_q <= MEM_RST;
		end else begin
			rd_tgl_s1_q <= rd_tgl_q;
			rd_tgl_s2_q <= rd_tgl_s1_q;
			rd_tgl_s3_q <= rd_tgl_s2_q;
			if (rd_tgl_s2_q != rd_tgl_s3_q) begin
				rd_hold_q <= rdata_q;
			end
		end
	end

	// data shift path: capture, shift, hold elsewhere
	always_ff @(posedge tck_in) begin
		if (tap_rst_q) begin
			dr_sh_q <= DR_RST;
		end else if (state_q == JT_CAPDR) begin
			unique case (ir_q)
				INS_IDCODE: dr_sh_q <= id_word;
				INS_USER_ID: dr_sh_q <= {16'h0000, user_s2_q};
				INS_LOAD_ADDR: dr_sh_q <= {24'h000000, addr_q};
				INS_READ_DATA: dr_sh_q <= {24'h000000, rd_hold_q};
				INS_WRITE_DATA: dr_sh_q <= {24'h000000, wdata_q};
				default: dr_sh_q <= dr_sh_q;
			endcase
		end else if (state_q == JT_SHDR) begin
			if (is_mem_ins) begin
				dr_sh_q <= {24'h000000, tdi_in, dr_sh_q[MEM_W-1:1]};
			end else begin
				dr_sh_q <= {tdi_in, dr_sh_q[ID_W-1:1]};
			end
		end
	end

	// one-bit bypass stage; captures zero
	always_ff @(posedge tck_in) begin
		if (tap_rst_q) begin
			bypass_q <= 1'b0;
		end else if (state_q == JT_CAPDR) begin
			bypass_q <= 1'b0;
		end else if (state_q == JT_SHDR) begin
			bypass_q <= tdi_in;
		end
	end

	// instruction latch and update latches on falling test clock
	always_ff @(negedge tck_in) begin
		if (tap_rst_q) begin
			ir_q <= INS_IDCODE;
			addr_q <= MEM_RST;
			wdata_q <= MEM_RST;
			cmd_q <= JC_NONE;
			req_tgl_q <= 1'b0;
		end else if (state_q == JT_TLR) begin
			ir_q <= INS_IDCODE;
		end else if (state_q == JT_UPDIR) begin
			ir_q <= ir_sh_q;
			unique case (ir_sh_q)
				INS_READ_DATA: begin
					cmd_q <= JC_RD;
					req_tgl_q <= ~req_tgl_q;
				end
				INS_REBOOT: begin
					cmd_q <= JC_REBOOT;
					req_tgl_q <= ~req_tgl_q;
				end
				INS_SAVE: begin
					cmd_q <= JC_SAVE;
					req_tgl_q <= ~req_tgl_q;
				end
				INS_EXT_ON: begin
					cmd_q <= JC_EXT_ON;
					req_tgl_q <= ~req_tgl_q;
				end
				INS_EXT_OFF: begin
					cmd_q <= JC_EXT_OFF;
					req_tgl_q <= ~req_tgl_q;
				end
				INS_EEP_ON: begin
					cmd_q <= JC_EEP_ON;
					req_tgl_q <= ~req_tgl_q;
				end
				INS_EEP_OFF: begin
					cmd_q <= JC_EEP_OFF;
					req_tgl_q <= ~req_tgl_q;
				end
				default: cmd_q <= cmd_q;
			endcase
		end else if (state_q == JT_UPDDR) begin
			unique case (ir_q)
				INS_LOAD_ADDR: begin
					addr_q <= dr_sh_q[MEM_W-1:0];
					cmd_q <= JC_ADDR;
					req_tgl_q <= ~req_tgl_q;
				end
				INS_WRITE_DATA: begin
					wdata_q <= dr_sh_q[MEM_W-1:0];
					cmd_q <= JC_WR;
					req_tgl_q <= ~req_tgl_q;
				end
				INS_READ_DATA: begin
					cmd_q <= JC_RD;
					req_tgl_q <= ~req_tgl_q;
				end
				default: cmd_q <= cmd_q;
			endcase
		end
	end

	// serial output on falling edge, driven only while shifting
	always_ff @(negedge tck_in) begin
		if (tap_rst_q) begin
			tdo_q <= 1'b0;
			tdo_oe_q <= 1'b0;
		end else begin
			tdo_oe_q <= (state_q == JT_SHDR) || (state_q == JT_SHIR);
			if (state_q == JT_SHIR) begin
				tdo_q <= ir_sh_q[0];
			end else if (state_q == JT_SHDR) begin
				tdo_q <= (ir_q == INS_BYPASS || !(is_mem_ins || ir_q == INS_IDCODE ||
					ir_q == INS_USER_ID)) ? bypass_q : dr_sh_q[0];
			end
		end
	end

	assign tdo_out = tdo_q;
	assign tdo_oe_out = tdo_oe_q;

	////////////////////////////////////////////////////////////////
	// system clock domain

	logic req_s1_q;
	logic req_s2_q;
	logic req_s3_q;
	logic busy_s1_q;
	logic busy_s2_q;
	logic [MEM_W-1:0] mem_addr_q;
	logic [MEM_W-1:0] mem_wdata_q;
	logic mem_wr_q;
	logic mem_rd_q;
	logic refused_q;
	logic reboot_q;
	logic save_q;
	logic ext_q;
	logic eep_q;
	logic req_ev;

	assign req_ev = req_s2_q ^ req_s3_q;

	// request toggle and busy level crossing from test clock
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			req_s1_q <= 1'b0;
			req_s2_q <= 1'b0;
			req_s3_q <= 1'b0;
			busy_s1_q <= 1'b0;
			busy_s2_q <= 1'b0;
		end else if (clk_en_in) begin
			req_s1_q <= req_tgl_q;
			req_s2_q <= req_s1_q;
			req_s3_q <= req_s2_q;
			busy_s1_q <= is_mem_ins;
			busy_s2_q <= busy_s1_q;
		end
	end

	// memory commands, refused while two-wire port holds memory
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			mem_addr_q <= MEM_RST;
			mem_wdata_q <= MEM_RST;
			mem_wr_q <= 1'b0;
			mem_rd_q <= 1'b0;
			refused_q <= 1'b0;
		end else if (clk_en_in) begin
			mem_wr_q <= 1'b0;
			mem_rd_q <= 1'b0;
			refused_q <= 1'b0;
			if (req_ev && (cmd_q == JC_ADDR || cmd_q == JC_WR || cmd_q == JC_RD)) begin
				if (twi_busy_in) begin
					refused_q <= 1'b1;
				end else if (cmd_q == JC_ADDR) begin
					mem_addr_q <= addr_q;
				end else if (cmd_q == JC_WR) begin
					mem_wdata_q <= wdata_q;
					mem_wr_q <= 1'b1;
				end else begin
					mem_rd_q <= 1'b1;
				end
			end
		end
	end

	// device actions and page selection
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			reboot_q <= 1'b0;
			save_q <= 1'b0;
			ext_q <= 1'b0;
			eep_q <= 1'b0;
		end else if (clk_en_in) begin
			reboot_q <= req_ev && (cmd_q == JC_REBOOT);
			save_q <= req_ev && (cmd_q == JC_SAVE);
			if (req_ev && cmd_q == JC_EXT_ON) begin
				ext_q <= 1'b1;
			end else if (req_ev && cmd_q == JC_EXT_OFF) begin
				ext_q <= 1'b0;
			end
			if (req_ev && cmd_q == JC_EEP_ON) begin
				eep_q <= 1'b1;
			end else if (req_ev && cmd_q == JC_EEP_OFF) begin
				eep_q <= 1'b0;
			end
		end
	end

	// read data held, toggle tells test clock side
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			rdata_q <= MEM_RST;
			rd_tgl_q <= 1'b0;
		end else if (clk_en_in && mem_rvalid_in) begin
			rdata_q <= mem_rdata_in;
			rd_tgl_q <= ~rd_tgl_q;
		end
	end

	assign mem_addr_out = mem_addr_q;
	assign mem_wdata_out = mem_wdata_q;
	assign mem_wr_out = mem_wr_q;
	assign mem_rd_out = mem_rd_q;
	assign mem_refused_out = refused_q;
	assign jtag_busy_out = busy_s2_q;
	assign reboot_out = reboot_q;
	assign save_out = save_q;
	assign ext_page_out = ext_q;
	assign eep_page_out = eep_q;

	////////////////////////////////////////////////////////////////
	// assertions

	sequence s_tms_high5;
		tms_in [*5];
	endsequence

	property p_five_high_reset;
		@(posedge tck_in) disable iff (tap_rst_q) s_tms_high5 |=> state_q == JT_TLR;
	endproperty
	a_five_high_reset: assert property (p_five_high_reset) else $error("no reset after five");

	property p_tlr_leave;
		@(posedge tck_in) disable iff (tap_rst_q)
			(state_q == JT_TLR && !tms_in) |=> state_q == JT_RTI;
	endproperty
	a_tlr_leave: assert property (p_tlr_leave) else $error("reset state exit wrong");

	property p_idle_hold;
		@(posedge tck_in) disable iff (tap_rst_q)
			state_q == JT_RTI |=> $stable(ir_sh_q) && $stable(dr_sh_q) && $stable(ir_q);
	endproperty
	a_idle_hold: assert property (p_idle_hold) else $error("idle changed registers");

	property p_seldr_branch;
		@(posedge tck_in) disable iff (tap_rst_q)
			state_q == JT_SELDR |=> state_q == ($past(tms_in) ? JT_SELIR : JT_CAPDR);
	endproperty
	a_seldr_branch: assert property (p_seldr_branch) else $error("select-DR branch wrong");

	property p_capture_id;
		@(posedge tck_in) disable iff (tap_rst_q)
			(state_q == JT_CAPDR && ir_q == INS_IDCODE) |=> dr_sh_q[0] == 1'b1;
	endproperty
	a_capture_id: assert property (p_capture_id) else $error("id word bit zero clear");

	property p_addr_shift;
		@(posedge tck_in) disable iff (tap_rst_q)
			(state_q == JT_SHDR && ir_q == INS_LOAD_ADDR) |=>
			dr_sh_q[7] == $past(tdi_in) && dr_sh_q[6:0] == $past(dr_sh_q[7:1]);
	endproperty
	a_addr_shift: assert property (p_addr_shift) else $error("address shift wrong");

	sequence s_pause_dr_stay;
		state_q == JT_PAUSEDR && !tms_in;
	endsequence

	property p_pause_hold;
		@(posedge tck_in) disable iff (tap_rst_q)
			s_pause_dr_stay |=> state_q == JT_PAUSEDR && $stable(dr_sh_q);
	endproperty
	a_pause_hold: assert property (p_pause_hold) else $error("pause-DR not holding");

	property p_capir_const;
		@(posedge tck_in) disable iff (tap_rst_q) state_q == JT_CAPIR |=> ir_sh_q == IR_CAPTURE;
	endproperty
	a_capir_const: assert property (p_capir_const) else $error("capture-IR value wrong");

	property p_update_ir;
		@(posedge tck_in) disable iff (tap_rst_q) state_q == JT_UPDIR |=> ir_q == $past(ir_sh_q);
	endproperty
	a_update_ir: assert property (p_update_ir) else $error("instruction not latched");

	// system reset covers the first test clock edges before the synchroniser fills
	property p_tdo_enable;
		@(posedge tck_in) disable iff (tap_rst_q || sys_rst_in)
			tdo_oe_q == (state_q == JT_SHDR || state_q == JT_SHIR);
	endproperty
	a_tdo_enable: assert property (p_tdo_enable) else $error("output enable wrong");

	property p_bypass_pass;
		@(posedge tck_in) disable iff (tap_rst_q)
			(state_q == JT_SHDR && ir_q == INS_BYPASS) |=> bypass_q == $past(tdi_in);
	endproperty
	a_bypass_pass: assert property (p_bypass_pass) else $error("bypass stage wrong");

	property p_refuse;
		@(posedge clk_in) disable iff (sys_rst_in)
			(clk_en_in && req_ev && twi_busy_in &&
			(cmd_q == JC_ADDR || cmd_q == JC_WR || cmd_q == JC_RD)) |=>
			refused_q && !mem_wr_q && !mem_rd_q && $stable(mem_addr_q);
	endproperty
	a_refuse: assert property (p_refuse) else $error("memory command not refused");

endmodule : jtmap_tap

// ===== hw/jtmap_pkg.sv
// constants and types for the test access port with memory access
// How it works
// - state moves on sampled mode-select each rising clock
// - power-up sits in reset with identification instruction
// - five high mode-select cycles reach reset state
// - run-test/idle leaves shift and instruction registers untouched; read data hold still loads
// - select-DR goes capture-DR low, select-IR high
// - capture-DR loads only loadable selected registers
// - shift-DR shifts selected register one stage
// - exit1-DR goes update-DR high, pause-DR low
// - pause-DR holds data, waits for high select
// - exit2-DR goes update-DR high, shift-DR low
// - update-DR falling edge copies shift path out
// - select-IR goes capture-IR low, reset high
// - capture-IR loads constant into instruction shifter
// - shift-IR shifts instruction, other registers hold
// - exit1-IR goes pause-IR low, update-IR high
// - pause-IR halts shifting until select goes high
// - exit2-IR goes update-IR high, shift-IR low
// - update-IR falling edge makes instruction current
// - only one serial port uses memory at once
// - no boundary scan; vendor memory instructions added
// - instruction shifter and latch are five bits
// - bypass passes data through one-bit register
// - identification word has one in bit zero
// - address-load selects eight-bit address register
package jtmap_pkg;

	// controller states
	typedef enum logic [3:0] {
		JT_TLR = 4'h0,
		JT_RTI = 4'h1,
		JT_SELDR = 4'h2,
		JT_CAPDR = 4'h3,
		JT_SHDR = 4'h4,
		JT_EX1DR = 4'h5,
		JT_PAUSEDR = 4'h6,
		JT_EX2DR = 4'h7,
		JT_UPDDR = 4'h8,
		JT_SELIR = 4'h9,
		JT_CAPIR = 4'hA,
		JT_SHIR = 4'hB,
		JT_EX1IR = 4'hC,
		JT_PAUSEIR = 4'hD,
		JT_EX2IR = 4'hE,
		JT_UPDIR = 4'hF
	} jtmap_state_t;

	// commands handed to the system clock side
	typedef enum logic [3:0] {
		JC_NONE = 4'h0,
		JC_ADDR = 4'h1,
		JC_WR = 4'h2,
		JC_RD = 4'h3,
		JC_REBOOT = 4'h4,
		JC_SAVE = 4'h5,
		JC_EXT_ON = 4'h6,
		JC_EXT_OFF = 4'h7,
		JC_EEP_ON = 4'h8,
		JC_EEP_OFF = 4'h9
	} jtmap_cmd_t;

	localparam int IR_W = 5;
	localparam int MEM_W = 8;
	localparam int ID_W = 32;

	// instruction codes
	localparam logic [IR_W-1:0] INS_BYPASS = 5'h1F;
	localparam logic [IR_W-1:0] INS_IDCODE = 5'h00;
	localparam logic [IR_W-1:0] INS_USER_ID = 5'h03;
	localparam logic [IR_W-1:0] INS_LOAD_ADDR = 5'h04;
	localparam logic [IR_W-1:0] INS_READ_DATA = 5'h05;
	localparam logic [IR_W-1:0] INS_WRITE_DATA = 5'h06;
	localparam logic [IR_W-1:0] INS_REBOOT = 5'h07;
	localparam logic [IR_W-1:0] INS_SAVE = 5'h08;
	localparam logic [IR_W-1:0] INS_EXT_ON = 5'h09;
	localparam logic [IR_W-1:0] INS_EXT_OFF = 5'h0A;
	localparam logic [IR_W-1:0] INS_EEP_ON = 5'h0B;
	localparam logic [IR_W-1:0] INS_EEP_OFF = 5'h0C;

	// constant loaded at capture-IR, reset values
	localparam logic [IR_W-1:0] IR_CAPTURE = 5'h01;
	localparam logic [MEM_W-1:0] MEM_RST = 8'h00;
	localparam logic [ID_W-1:0] DR_RST = 32'h00000000;
	localparam int TMS_RESET_CYC = 5;

endpackage : jtmap_pkg

// ===== tb/jtmap_host.sv
// test host model driving the test port pins
`timescale 1ns/100ps
module jtmap_host (
	// test port pins
	output logic tck_out,
	output logic tms_out,
	output logic tdi_out,
	input wire logic tdo_in,
	input wire logic tdo_oe_in
);
	logic dmy_o;
	logic dmy_e;
	// clock parked low, mode select high at start
	initial begin
		tck_out = 1'b0;
		tms_out = 1'b1;
		tdi_out = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////////////
	// one test clock period, out sampled before the rising edge
	task cyc(input logic m, input logic d, output logic o, output logic e);
		tms_out = m;
		tdi_out = d;
		#40;
		o = tdo_in;
		e = tdo_oe_in;
		tck_out = 1'b1;
		#40;
		tck_out = 1'b0;
	endtask : cyc
	// one period with a changing data line
	task step(input logic m);
		cyc(m, ~tdi_out, dmy_o, dmy_e);
	endtask : step
	// resynchronise, then settle in idle
	task rst5();
		repeat (5) step(1'b1);
		step(1'b0);
	endtask : rst5
	// idle to idle scan, lsb first, optional pause detour
	task scan(input logic ir, input int n, input logic [31:0] din, input logic pz,
		output logic [31:0] dout, output logic oe_all);
		logic o;
		logic e;
		dout = '0;
		oe_all = 1'b1;
		step(1'b1);
		if (ir) begin
			step(1'b1);
		end
		step(1'b0);
		step(1'b0);
		for (int i = 0; i < n; i++) begin
			cyc(i == n - 1, din[i], o, e);
			dout[i] = o;
			oe_all = oe_all & e;
		end
		if (pz) begin
			step(1'b0);
			step(1'b0);
			step(1'b1);
		end
		step(1'b1);
		step(1'b0);
		tdi_out = ~tdi_out;
	endtask : scan
endmodule : jtmap_host

// ===== tb/tb.sv
// self-checking bench for the test access port
`timescale 1ns/100ps
module tb import jtmap_pkg::*;;
	localparam logic [3:0] T_VER = 4'h6; // arbitrary value
	localparam logic [15:0] T_PART = 16'h1234; // arbitrary value
	localparam logic [10:0] T_MAKER = 11'h0A5; // arbitrary value
	localparam logic [7:0] RD_BYTE = 8'h5E;
	localparam logic [15:0] USER = 16'hC3E1;
	logic clk_in, sys_rst_in, clk_en_in, tck, tms, tdi, tdo, tdo_oe;
	logic [7:0] mem_addr, mem_wdata, mem_rdata;
	logic mem_wr, mem_rd, mem_rvalid, twi_busy, jtag_busy, refused;
	logic reboot, save, ext_page, eep_page;
	logic [31:0] dout;
	logic oe;
	int error_cnt;
	int cmp_count;
	int pcnt [5];
	////////////////////////////////////////////////////////////////////////////////
	// design and host
	jtmap_tap #(.ID_VERSION(T_VER), .ID_PART(T_PART), .ID_MAKER(T_MAKER)) jtmap_tap_inst (
		.clk_in(clk_in), .sys_rst_in(sys_rst_in), .clk_en_in(clk_en_in),
		.tck_in(tck), .tms_in(tms), .tdi_in(tdi), .tdo_out(tdo), .tdo_oe_out(tdo_oe),
		.mem_addr_out(mem_addr), .mem_wdata_out(mem_wdata), .mem_wr_out(mem_wr),
		.mem_rd_out(mem_rd), .mem_rdata_in(mem_rdata), .mem_rvalid_in(mem_rvalid),
		.twi_busy_in(twi_busy), .jtag_busy_out(jtag_busy), .mem_refused_out(refused),
		.reboot_out(reboot), .save_out(save), .ext_page_out(ext_page),
		.eep_page_out(eep_page), .user_code_in(USER));
	jtmap_host jtmap_host_inst (.tck_out(tck), .tms_out(tms), .tdi_out(tdi),
		.tdo_in(tdo), .tdo_oe_in(tdo_oe));
	// system clock
	initial begin
		clk_in = 1'b0;
		forever #20 clk_in = ~clk_in;
	end
	// strobe pulse counters
	always @(posedge clk_in) begin
		if (mem_wr === 1'b1) pcnt[0]++;
		if (mem_rd === 1'b1) pcnt[1]++;
		if (refused === 1'b1) pcnt[2]++;
		if (reboot === 1'b1) pcnt[3]++;
		if (save === 1'b1) pcnt[4]++;
	end
	// memory answers each read one cycle later
	always @(posedge clk_in) begin
		if (mem_rd === 1'b1) begin
			#1 mem_rvalid = 1'b1;
			mem_rdata = RD_BYTE;
			@(posedge clk_in);
			#1 mem_rvalid = 1'b0;
			mem_rdata = ~RD_BYTE;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// compare and close
	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task complete_run();
		$display("checks %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : complete_run
	task wait_mem();
		repeat (12) @(posedge clk_in);
		#1;
	endtask : wait_mem
	task ir_load(input logic [4:0] ins, input logic pz);
		jtmap_host_inst.scan(1'b1, 5, {27'h0, ins}, pz, dout, oe);
		chk("ir capture", {27'h0, IR_CAPTURE}, dout);
	endtask : ir_load
	task dr8(input logic [7:0] d, input logic pz);
		jtmap_host_inst.scan(1'b0, 8, {24'h0, d}, pz, dout, oe);
	endtask : dr8
	////////////////////////////////////////////////////////////////////////////////
	// scenarios
	task t_idcode();
		jtmap_host_inst.scan(1'b0, 32, 32'h0, 1'b0, dout, oe);
		chk("idcode", {T_VER, T_PART, T_MAKER, 1'b1}, dout);
		chk("oe shift", 32'h1, {31'h0, oe});
		chk("oe idle", 32'h0, {31'h0, tdo_oe});
	endtask : t_idcode
	task t_bypass_reset();
		ir_load(INS_BYPASS, 1'b1);
		dr8(8'hB4, 1'b1);
		chk("bypass", {24'h0, 8'hB4 << 1}, dout);
		jtmap_host_inst.step(1'b1);
		jtmap_host_inst.step(1'b0);
		jtmap_host_inst.step(1'b0);
		jtmap_host_inst.rst5();
		t_idcode();
	endtask : t_bypass_reset
	task t_mem();
		int b;
		ir_load(INS_LOAD_ADDR, 1'b0);
		wait_mem();
		chk("jtag busy", 32'h1, {31'h0, jtag_busy});
		dr8(8'h3C, 1'b0);
		wait_mem();
		chk("addr", 32'h3C, {24'h0, mem_addr});
		ir_load(INS_WRITE_DATA, 1'b0);
		b = pcnt[0];
		dr8(8'hA5, 1'b1);
		wait_mem();
		chk("write count", b + 1, pcnt[0]);
		chk("wdata", 32'hA5, {24'h0, mem_wdata});
		twi_busy = 1'b1;
		ir_load(INS_LOAD_ADDR, 1'b0);
		b = pcnt[2];
		dr8(8'h77, 1'b0);
		wait_mem();
		chk("refused count", b + 1, pcnt[2]);
		chk("addr held", 32'h3C, {24'h0, mem_addr});
		@(posedge clk_in);
		#1 twi_busy = 1'b0;
		b = pcnt[1];
		ir_load(INS_READ_DATA, 1'b0);
		wait_mem();
		chk("read count", b + 1, pcnt[1]);
		// idle test clocks carry the returned byte into the test clock side
		repeat (3) jtmap_host_inst.step(1'b0);
		dr8(8'h00, 1'b0);
		chk("read data", {24'h0, RD_BYTE}, dout);
		ir_load(user_id_instr_code(), 1'b0);
		jtmap_host_inst.scan(1'b0, 32, 32'h0, 1'b0, dout, oe);
		chk("user word", {16'h0, USER}, dout);
	endtask : t_mem
	function automatic logic [4:0] user_id_instr_code();
		return INS_USER_ID;
	endfunction : user_id_instr_code
	task t_actions();
		logic [4:0] ins [6];
		int b3;
		int b4;
		ins = '{INS_REBOOT, INS_SAVE, INS_EXT_ON, INS_EEP_ON, INS_EXT_OFF, INS_EEP_OFF};
		for (int k = 0; k < 6; k++) begin
			b3 = pcnt[3];
			b4 = pcnt[4];
			ir_load(ins[k], 1'b0);
			wait_mem();
			chk("reboot", b3 + (k == 0), pcnt[3]);
			chk("save", b4 + (k == 1), pcnt[4]);
			chk("ext page", (k == 2 || k == 3), {31'h0, ext_page});
			chk("eep page", (k == 3 || k == 4), {31'h0, eep_page});
		end
		chk("jtag idle", 32'h0, {31'h0, jtag_busy});
		// clock enable low freezes the system side until it returns
		clk_en_in = 1'b0;
		ir_load(INS_EXT_ON, 1'b0);
		wait_mem();
		chk("ext frozen", 32'h0, {31'h0, ext_page});
		clk_en_in = 1'b1;
		wait_mem();
		chk("ext late", 32'h1, {31'h0, ext_page});
	endtask : t_actions
	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		sys_rst_in = 1'b1;
		clk_en_in = 1'b1;
		twi_busy = 1'b0;
		mem_rvalid = 1'b0;
		mem_rdata = 8'h00;
		fork
			repeat (6) @(posedge clk_in);
			repeat (3) jtmap_host_inst.step(1'b1);
		join
		@(posedge clk_in);
		#1 sys_rst_in = 1'b0;
		jtmap_host_inst.rst5();
		t_idcode();
		t_bypass_reset();
		t_mem();
		t_actions();
		complete_run();
	end
	// watchdog
	initial begin
		#400000;
		error_cnt++;
		complete_run();
	end
endmodule : tb
